// ==== rtl/io_ports_defines.vh ====
// Purpose: offsets, field positions, reset values and mode codes of the io ports
// Assumes: register offsets are word indices on the avalon-mm slave
// Notes:   definitions only
`ifndef IO_PORTS_DEFINES_VH
`define IO_PORTS_DEFINES_VH

// --------------------------------------------------------------------
// register word indices
// --------------------------------------------------------------------
`define P7_DATA_IDX      16'hffda
`define P8_DATA_IDX      16'hffdb
`define PA_DATA_IDX      16'hffdd
`define P7_DIR_IDX       16'hffea
`define P8_DIR_IDX       16'hffeb
`define PA_DIR_IDX       16'hffed
`define PORT_STATUS_IDX  16'hfff0

// --------------------------------------------------------------------
// reset values and field layout
// --------------------------------------------------------------------
`define P7_DATA_RST      8'h00
`define P7_DIR_RST       8'h00
`define P8_DATA_RST      8'h00
`define P8_DIR_RST       8'h00
`define PA_DATA_RST      8'hf0
`define PA_DIR_RST       8'hf1
`define PA_LSB           1
`define PA_MSB           3
`define PA_UNUSED_MASK   8'hf1
`define WO_READ_VALUE    8'hff
`define UNMAPPED_READ    8'h00

// --------------------------------------------------------------------
// operating modes
// --------------------------------------------------------------------
`define MODE_ACTIVE      3'h0
`define MODE_SUBACTIVE   3'h1
`define MODE_SLEEP       3'h2
`define MODE_SUBSLEEP    3'h3
`define MODE_WATCH       3'h4
`define MODE_STANDBY     3'h5

`endif

// ==== rtl/io_pin_bank.v ====
// Purpose: pin drivers and input synchronisers for one group of port pins
// Assumes: pin_float and pin_hold come from logic on ref_clk
// Notes:   pin_oe_n is low while a pin is driven
`timescale 1ns/1ps
`default_nettype none

module io_pin_bank #(
	parameter WIDTH = 8
) (
	input  wire             ref_clk,
	input  wire             reset,
	input  wire             pin_float,
	input  wire             pin_hold,
	input  wire [WIDTH-1:0] data_bits,
	input  wire [WIDTH-1:0] dir_bits,
	input  wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_level,
	output wire [WIDTH-1:0] pin_out,
	output wire [WIDTH-1:0] pin_oe_n
);

	// ----------------------------------------------------------------
	// per-bit synchroniser and driver
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg sync1_q;
			reg sync2_q;
			reg out_q;
			reg oe_n_q;

			always @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					sync1_q <= 1'b0;
					sync2_q <= 1'b0;
				end else begin
					sync1_q <= pin_in[i];
					sync2_q <= sync1_q;
				end
			end

			always @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					out_q  <= 1'b0;
					oe_n_q <= 1'b1;
				end else if (pin_float) begin
					oe_n_q <= 1'b1;
				end else if (!pin_hold) begin
					out_q  <= data_bits[i];
					oe_n_q <= ~dir_bits[i];
				end
			end

			assign pin_level[i] = sync2_q;
			assign pin_out[i]   = out_q;
			assign pin_oe_n[i]  = oe_n_q;
		end
	endgenerate

endmodule // io_pin_bank

`default_nettype wire

// ==== rtl/io_ports.v ====
// Purpose: port 7, port 8 and port a registers and pin control
// Assumes: avalon-mm slave with 8-bit data; address is the register word index
// Notes:   op_mode comes from the power controller on ref_clk
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "io_ports_defines.vh"

module io_ports #(
	parameter P7_WIDTH = 8,
	parameter P8_WIDTH = 8,
	parameter PA_WIDTH = 3
) (
	input  wire                ref_clk,
	input  wire                reset,
	input  wire [15:0]         address,
	input  wire                read,
	input  wire                write,
	input  wire [7:0]          writedata,
	output wire [7:0]          readdata,
	output wire                waitrequest,
	input  wire [2:0]          op_mode,
	input  wire [P7_WIDTH-1:0] port7_pin_in,
	output wire [P7_WIDTH-1:0] port7_pin_out,
	output wire [P7_WIDTH-1:0] port7_pin_oe_n,
	input  wire [P8_WIDTH-1:0] port8_pin_in,
	output wire [P8_WIDTH-1:0] port8_pin_out,
	output wire [P8_WIDTH-1:0] port8_pin_oe_n,
	input  wire [PA_WIDTH-1:0] porta_pin_in,
	output wire [PA_WIDTH-1:0] porta_pin_out,
	output wire [PA_WIDTH-1:0] porta_pin_oe_n
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	localparam [7:0]    PA_DATA_RST_V = `PA_DATA_RST;
	localparam [7:0]    PA_DIR_RST_V  = `PA_DIR_RST;
	reg  [P7_WIDTH-1:0] port7_data_q;
	reg  [P7_WIDTH-1:0] port7_direction_q;
	reg  [P8_WIDTH-1:0] port8_data_q;
	reg  [P8_WIDTH-1:0] port8_direction_q;
	reg  [PA_WIDTH-1:0] porta_data_q;
	reg  [PA_WIDTH-1:0] porta_direction_q;
	reg  [7:0]          readdata_q;
	reg  [7:0]          readdata_d;
	reg                 waitrequest_q;
	reg                 pin_float_q;
	reg                 pin_hold_q;
	reg                 pin_float_d;
	reg                 pin_hold_d;

	// ----------------------------------------------------------------
	// pin levels and bus decode
	// ----------------------------------------------------------------
	wire [P7_WIDTH-1:0] port7_level;
	wire [P8_WIDTH-1:0] port8_level;
	wire [PA_WIDTH-1:0] porta_level;
	wire                req;
	wire                wr_go;
	wire                sel_p7_data;
	wire                sel_p7_dir;
	wire                sel_p8_data;
	wire                sel_p8_dir;
	wire                sel_pa_data;
	wire                sel_pa_dir;
	wire [P7_WIDTH-1:0] port7_view;
	wire [P8_WIDTH-1:0] port8_view;
	wire [PA_WIDTH-1:0] porta_view;
	wire [7:0]          porta_read;

	assign req         = read | write;
	assign wr_go       = write & ~waitrequest_q;
	assign sel_p7_data = (address == `P7_DATA_IDX);
	assign sel_p7_dir  = (address == `P7_DIR_IDX);
	assign sel_p8_data = (address == `P8_DATA_IDX);
	assign sel_p8_dir  = (address == `P8_DIR_IDX);
	assign sel_pa_data = (address == `PA_DATA_IDX);
	assign sel_pa_dir  = (address == `PA_DIR_IDX);

	// ----------------------------------------------------------------
	// read views: latch where output, pin level where input
	// ----------------------------------------------------------------
	assign port7_view = (port7_direction_q & port7_data_q)
		| (~port7_direction_q & port7_level);
	assign port8_view = (port8_direction_q & port8_data_q)
		| (~port8_direction_q & port8_level);
	assign porta_view = (porta_direction_q & porta_data_q)
		| (~porta_direction_q & porta_level);

	// unused porta positions read as one
	assign porta_read = {4'hf, porta_view, 1'b1};

	// ----------------------------------------------------------------
	// operating mode to pin behaviour
	// ----------------------------------------------------------------
	always @* begin
		pin_float_d = 1'b0;
		pin_hold_d  = 1'b0;
		case (op_mode)
			`MODE_ACTIVE: begin
				pin_hold_d = 1'b0;
			end
			`MODE_SUBACTIVE: begin
				pin_hold_d = 1'b0;
			end
			`MODE_SLEEP: begin
				pin_hold_d = 1'b1;
			end
			`MODE_SUBSLEEP: begin
				pin_hold_d = 1'b1;
			end
			`MODE_WATCH: begin
				pin_hold_d = 1'b1;
			end
			`MODE_STANDBY: begin
				pin_float_d = 1'b1;
			end
			default: begin
				pin_float_d = 1'b1;
			end
		endcase
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_float_q <= 1'b1;
			pin_hold_q  <= 1'b0;
		end else begin
			pin_float_q <= pin_float_d;
			pin_hold_q  <= pin_hold_d;
		end
	end

	// ----------------------------------------------------------------
	// port 7 registers
	// ----------------------------------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			port7_data_q <= `P7_DATA_RST;
		end else if (wr_go && sel_p7_data) begin
			port7_data_q <= writedata[P7_WIDTH-1:0];
		end
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			port7_direction_q <= `P7_DIR_RST;
		end else if (wr_go && sel_p7_dir) begin
			port7_direction_q <= writedata[P7_WIDTH-1:0];
		end
	end

	// ----------------------------------------------------------------
	// port 8 registers
	// ----------------------------------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			port8_data_q <= `P8_DATA_RST;
		end else if (wr_go && sel_p8_data) begin
			port8_data_q <= writedata[P8_WIDTH-1:0];
		end
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			port8_direction_q <= `P8_DIR_RST;
		end else if (wr_go && sel_p8_dir) begin
			port8_direction_q <= writedata[P8_WIDTH-1:0];
		end
	end

	// ----------------------------------------------------------------
	// port a registers, only bits 3 to 1 are stored
	// ----------------------------------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			porta_data_q <= PA_DATA_RST_V[`PA_MSB:`PA_LSB];
		end else if (wr_go && sel_pa_data) begin
			porta_data_q <= writedata[`PA_MSB:`PA_LSB];
		end
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			porta_direction_q <= PA_DIR_RST_V[`PA_MSB:`PA_LSB];
		end else if (wr_go && sel_pa_dir) begin
			porta_direction_q <= writedata[`PA_MSB:`PA_LSB];
		end
	end

	// ----------------------------------------------------------------
	// read data mux
	// ----------------------------------------------------------------
	always @* begin
		readdata_d = `UNMAPPED_READ;
		case (address)
			`P7_DATA_IDX: begin
				readdata_d = port7_view;
			end
			`P7_DIR_IDX: begin
				readdata_d = `WO_READ_VALUE;
			end
			`P8_DATA_IDX: begin
				readdata_d = port8_view;
			end
			`P8_DIR_IDX: begin
				readdata_d = `WO_READ_VALUE;
			end
			`PA_DATA_IDX: begin
				readdata_d = porta_read;
			end
			`PA_DIR_IDX: begin
				readdata_d = `WO_READ_VALUE;
			end
			`PORT_STATUS_IDX: begin
				readdata_d = {3'h0, pin_float_q, pin_hold_q, op_mode};
			end
			default: begin
				readdata_d = `UNMAPPED_READ;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// avalon handshake: one wait cycle, then one ready cycle
	// ----------------------------------------------------------------
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			waitrequest_q <= 1'b1;
			readdata_q    <= 8'h00;
		end else begin
			waitrequest_q <= ~(req & waitrequest_q);
			if (read && waitrequest_q) begin
				readdata_q <= readdata_d;
			end
		end
	end

	assign readdata    = readdata_q;
	assign waitrequest = waitrequest_q;

	// ----------------------------------------------------------------
	// pin banks
	// ----------------------------------------------------------------
	io_pin_bank #(
		.WIDTH (P7_WIDTH)
	) u_port7 (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.pin_float (pin_float_q),
		.pin_hold  (pin_hold_q),
		.data_bits (port7_data_q),
		.dir_bits  (port7_direction_q),
		.pin_in    (port7_pin_in),
		.pin_level (port7_level),
		.pin_out   (port7_pin_out),
		.pin_oe_n  (port7_pin_oe_n)
	);

	io_pin_bank #(
		.WIDTH (P8_WIDTH)
	) u_port8 (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.pin_float (pin_float_q),
		.pin_hold  (pin_hold_q),
		.data_bits (port8_data_q),
		.dir_bits  (port8_direction_q),
		.pin_in    (port8_pin_in),
		.pin_level (port8_level),
		.pin_out   (port8_pin_out),
		.pin_oe_n  (port8_pin_oe_n)
	);

	io_pin_bank #(
		.WIDTH (PA_WIDTH)
	) u_porta (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.pin_float (pin_float_q),
		.pin_hold  (pin_hold_q),
		.data_bits (porta_data_q),
		.dir_bits  (porta_direction_q),
		.pin_in    (porta_pin_in),
		.pin_level (porta_level),
		.pin_out   (porta_pin_out),
		.pin_oe_n  (porta_pin_oe_n)
	);

endmodule // io_ports

`default_nettype wire

// ==== verification/io_ports_chk.sv ====
// Purpose: bus and pin checks for io_ports
// Assumes: bound into io_ports
// Notes:   port 8 registers shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "io_ports_defines.vh"
module io_ports_chk (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic [15:0] address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [7:0]  writedata,
	input wire logic [7:0]  readdata,
	input wire logic        waitrequest,
	input wire logic [2:0]  op_mode,
	input wire logic [7:0]  port7_pin_oe_n,
	input wire logic [7:0]  port8_pin_out,
	input wire logic [7:0]  port8_pin_oe_n,
	input wire logic [2:0]  porta_pin_oe_n
);
	// ----
	// shadow of port 8 registers
	// ----
	logic [7:0] dir8_q;
	logic [7:0] dat8_q;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			dir8_q <= 8'h00;
			dat8_q <= 8'h00;
		end else if (write && !waitrequest) begin
			if (address == `P8_DIR_IDX) dir8_q <= writedata;
			if (address == `P8_DATA_IDX) dat8_q <= writedata;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence settled;
		(op_mode == `MODE_ACTIVE)[*3] ##0 $stable(dir8_q) && $stable(dat8_q);
	endsequence
	wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer after one wait cycle");
	wait_pulse_a: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	dir_read_a: assert property (read && waitrequest && (address == `P8_DIR_IDX ||
		address == `PA_DIR_IDX || address == `P7_DIR_IDX) |=> readdata == 8'hff)
		else $error("direction read not all ones");
	pa_unused_a: assert property (read && waitrequest && address == `PA_DATA_IDX
		|=> readdata[7:4] == 4'hf && readdata[0])
		else $error("unused port a bits not one");
	p8_latch_a: assert property (read && waitrequest && address == `P8_DATA_IDX
		|=> ((readdata ^ dat8_q) & dir8_q) == 8'h00)
		else $error("output bit read not latch");
	p8_dir_a: assert property (settled |-> port8_pin_oe_n == ~dir8_q)
		else $error("drive enable not per direction");
	p8_out_a: assert property (settled |-> ((port8_pin_out ^ dat8_q) & dir8_q) == 8'h00)
		else $error("driven level not latch");
	sleep_hold_a: assert property ((op_mode >= 3'h2 && op_mode <= 3'h4)[*3]
		|-> $stable(port8_pin_out) && $stable(port8_pin_oe_n))
		else $error("pins moved while held");
	standby_float_a: assert property ((op_mode >= `MODE_STANDBY)[*3]
		|-> &port8_pin_oe_n && &port7_pin_oe_n && &porta_pin_oe_n)
		else $error("pins driven in standby");
	cover property (write && !waitrequest);
	cover property ((op_mode == `MODE_WATCH)[*3]);
	cover property ((op_mode == `MODE_STANDBY)[*3]);
endmodule // io_ports_chk
bind io_ports io_ports_chk chk_u (.ref_clk, .reset, .address, .read, .write, .writedata,
	.readdata, .waitrequest, .op_mode, .port7_pin_oe_n, .port8_pin_out, .port8_pin_oe_n,
	.porta_pin_oe_n);
`default_nettype wire

// ==== verification/pin_partner.sv ====
// Purpose: external circuit on a group of port pins
// Assumes: outside source drives every released pin
// Notes:   combinational
`timescale 1ns/1ps
`default_nettype none
module pin_partner #(
	parameter W = 8
) (
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe_n,
	input  wire logic [W-1:0] ext_val,
	output wire logic [W-1:0] pin_in
);
	// driven bits follow the port, released bits the outside source
	assign pin_in = (ext_val & pin_oe_n) | (pin_out & ~pin_oe_n);
endmodule // pin_partner
`default_nettype wire

// ==== verification/tb_io_ports.sv ====
// Purpose: self-checking bench for io_ports
// Assumes: one wait cycle per bus access
// Notes:   random registers and pin levels, seed 59
`timescale 1ns/1ps
`default_nettype none
`include "io_ports_defines.vh"
module tb_io_ports;
	logic        ref_clk = 0;
	logic        reset = 1;
	logic [15:0] address = 16'h0000;
	logic        read = 0;
	logic        write = 0;
	logic [7:0]  writedata = 8'h00;
	logic [7:0]  readdata;
	logic        waitrequest;
	logic [2:0]  op_mode = 3'h0;
	logic [7:0]  e7 = 8'h00, e8 = 8'h00, o7, n7, i7, o8, n8, i8, q, d7, r7, d8, r8, da, ra;
	logic [2:0]  ea = 3'h0, oa, na, ia;
	int          num_errors = 0;
	int          checks_done = 0;
	io_ports dut_u (.ref_clk, .reset, .address, .read, .write, .writedata, .readdata,
		.waitrequest, .op_mode, .port7_pin_in(i7), .port7_pin_out(o7), .port7_pin_oe_n(n7),
		.port8_pin_in(i8), .port8_pin_out(o8), .port8_pin_oe_n(n8),
		.porta_pin_in(ia), .porta_pin_out(oa), .porta_pin_oe_n(na));
	pin_partner #(.W(8)) p7_u (.pin_out(o7), .pin_oe_n(n7), .ext_val(e7), .pin_in(i7));
	pin_partner #(.W(8)) p8_u (.pin_out(o8), .pin_oe_n(n8), .ext_val(e8), .pin_in(i8));
	pin_partner #(.W(3)) pa_u (.pin_out(oa), .pin_oe_n(na), .ext_val(ea), .pin_in(ia));
	initial forever #4 ref_clk = ~ref_clk;
	// ----
	// tasks
	// ----
	function automatic logic [7:0] exp_rd(logic [7:0] d, logic [7:0] r, logic [7:0] e);
		return (d & r) | (e & ~r);
	endfunction
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		@(posedge ref_clk);
		while (waitrequest !== 1'b0) @(posedge ref_clk);
		q = readdata;
		write <= 0;
		read <= 0;
	endtask
	task final_report;
		if (num_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		final_report;
	end
	// ----
	// tests
	// ----
	initial begin
		void'($urandom(59));
		repeat (4) @(posedge ref_clk);
		chk(n8 & n7, 8'hff);
		chk({5'h1f, na}, 8'hff);
		reset <= 0;
		e7 <= 8'($urandom);
		e8 <= 8'($urandom);
		ea <= 3'($urandom);
		repeat (4) @(posedge ref_clk);
		acc(0, `P8_DATA_IDX, 0); chk(q, e8);
		acc(0, `P7_DATA_IDX, 0); chk(q, e7);
		acc(0, `PA_DATA_IDX, 0); chk(q, {4'hf, ea, 1'b1});
		acc(0, `P7_DIR_IDX, 0); chk(q, 8'hff);
		acc(0, `P8_DIR_IDX, 0); chk(q, 8'hff);
		acc(0, `PA_DIR_IDX, 0); chk(q, 8'hff);
		acc(0, 16'hff00, 0); chk(q, 8'h00);
		for (int k = 0; k < 24; k++) begin
			{d7, r7, d8, r8} = $urandom;
			{da, ra} = 16'($urandom);
			if (k < 2) r8 = {8{k[0]}};
			e7 <= 8'($urandom);
			e8 <= 8'($urandom);
			ea <= 3'($urandom);
			acc(1, `P7_DIR_IDX, r7);
			acc(1, `P7_DATA_IDX, d7);
			acc(1, `P8_DIR_IDX, r8);
			acc(1, `P8_DATA_IDX, d8);
			acc(1, `PA_DIR_IDX, ra);
			acc(1, `PA_DATA_IDX, da);
			repeat (4) @(posedge ref_clk);
			acc(0, `P7_DATA_IDX, 0); chk(q, exp_rd(d7, r7, e7));
			acc(0, `P8_DATA_IDX, 0); chk(q, exp_rd(d8, r8, e8));
			acc(0, `PA_DATA_IDX, 0); chk(q, exp_rd(da, ra, {4'h0, ea, 1'b0}) | 8'hf1);
			chk(n7, ~r7);
			chk(n8, ~r8);
			chk(o8 & r8, d8 & r8);
			chk(o7 & r7, d7 & r7);
			chk({5'h0, oa & ra[3:1]}, {5'h0, da[3:1] & ra[3:1]});
			chk({5'h0, na}, {5'h0, ~ra[3:1]});
		end
		acc(1, `P8_DIR_IDX, 8'hff);
		for (int m = 0; m < 8; m++) begin
			op_mode <= 3'(m);
			r8 = 8'($urandom);
			repeat (4) @(posedge ref_clk);
			acc(1, `P8_DATA_IDX, r8);
			repeat (4) @(posedge ref_clk);
			if (m < 5) chk(o8, m < 2 ? r8 : d8);
			chk(n8 & n7, m < 5 ? 8'h00 : 8'hff);
			if (m > 4) chk({5'h1f, na}, 8'hff);
			acc(0, `PORT_STATUS_IDX, 0);
			chk(q, {3'h0, (m > 4), (m > 1 && m < 5), 3'(m)});
			op_mode <= 3'h0;
			repeat (4) @(posedge ref_clk);
			chk(o8, r8);
			d8 = r8;
		end
		@(posedge ref_clk);
		reset <= 1;
		@(posedge ref_clk);
		chk(n8, 8'hff);
		reset <= 0;
		acc(1, `P8_DIR_IDX, 8'hff);
		acc(0, `P8_DATA_IDX, 0); chk(q, 8'h00);
		acc(1, `PA_DIR_IDX, 8'h0e);
		acc(0, `PA_DATA_IDX, 0); chk(q, 8'hf1);
		final_report;
	end
endmodule // tb_io_ports
`default_nettype wire
